/* File: core/asc_pkg.sv */
// constants for the step 8 configuration register of converter a
package asc_pkg;
  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int          ADDR_W      = 12;
  localparam int          DATA_W      = 32;
  localparam int          CFG_W       = 16;
  localparam logic [7:0]  STEP8_INDEX = 8'h98;
  localparam logic [11:0] STEP8_ADDR  = {2'h0, STEP8_INDEX, 2'h0};
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // ----------------------------------------------------------------
  // field layout and reset
  // ----------------------------------------------------------------
  localparam int          EN_BIT      = 15;
  localparam int          GAIN_HI     = 14;
  localparam int          GAIN_LO     = 13;
  localparam int          RSV_HI      = 12;
  localparam int          RSV_LO      = 5;
  localparam int          NEG_BIT     = 4;
  localparam int          POS_HI      = 3;
  localparam int          POS_LO      = 0;
  localparam logic [15:0] CFG_RESET   = 16'h0008;
  localparam logic [15:0] CFG_WMASK   = 16'hE01F;
  // ----------------------------------------------------------------
  // gain codes and factors
  // ----------------------------------------------------------------
  localparam logic [1:0]  GAIN_C1     = 2'h0;
  localparam logic [1:0]  GAIN_C2     = 2'h1;
  localparam logic [2:0]  GAIN_X1     = 3'h1;
  localparam logic [2:0]  GAIN_X2     = 3'h2;
  localparam logic [2:0]  GAIN_X4     = 3'h4;
  // ----------------------------------------------------------------
  // positive input codes; internal sources are one-hot index code-8
  // ----------------------------------------------------------------
  localparam logic [3:0]  POS_TEMP    = 4'h8;
  localparam logic [3:0]  POS_SHORT   = 4'h9;
  localparam logic [3:0]  POS_TDAC    = 4'hA;
  localparam logic [3:0]  POS_ASUP4   = 4'hB;
  localparam logic [3:0]  POS_IOSUP4  = 4'hC;
  localparam logic [3:0]  POS_DSUP2   = 4'hD;
  localparam logic [3:0]  POS_APIN    = 4'hE;
  localparam logic [3:0]  POS_DPIN    = 4'hF;
  localparam int          N_EXT       = 8;
  localparam int          N_INT       = 8;
  localparam logic [7:0]  RST_INT_SEL = 8'h01;
endpackage

/* File: core/asc_reg_if.sv */
// register access carrier between bus slave and register bank
`timescale 1ns/1ps
interface asc_reg_if;
  logic                           wr_en;
  logic [asc_pkg::ADDR_W-1:0]     wr_addr;
  logic [asc_pkg::DATA_W-1:0]     wr_data;
  logic [asc_pkg::DATA_W/8-1:0]   wr_strb;
  logic                           wr_hit;
  logic                           rd_en;
  logic [asc_pkg::ADDR_W-1:0]     rd_addr;
  logic [asc_pkg::DATA_W-1:0]     rd_data;
  logic                           rd_hit;
  modport slave (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                 input  wr_hit, rd_data, rd_hit);
  modport bank  (input  wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                 output wr_hit, rd_data, rd_hit);
endinterface // asc_reg_if

/* File: core/asc_axil_slave.sv */
// axi4-lite slave front end, one write and one read in flight
`timescale 1ns/1ps
module asc_axil_slave (
  // clock and reset
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // write channels
  input  wire logic [asc_pkg::ADDR_W-1:0]    awaddr,
  input  wire logic                          awvalid,
  output logic                               awready,
  input  wire logic [asc_pkg::DATA_W-1:0]    wdata,
  input  wire logic [asc_pkg::DATA_W/8-1:0]  wstrb,
  input  wire logic                          wvalid,
  output logic                               wready,
  output logic [1:0]                         bresp,
  output logic                               bvalid,
  input  wire logic                          bready,
  // read channels
  input  wire logic [asc_pkg::ADDR_W-1:0]    araddr,
  input  wire logic                          arvalid,
  output logic                               arready,
  output logic [asc_pkg::DATA_W-1:0]         rdata,
  output logic [1:0]                         rresp,
  output logic                               rvalid,
  input  wire logic                          rready,
  // register side
  asc_reg_if.slave                           regs
);
  logic aw_full;
  logic w_full;
  // handshakes and strobes toward the bank
  wire aw_take = awvalid && awready;
  wire w_take  = wvalid && wready;
  assign regs.wr_en   = aw_full && w_full;
  assign regs.rd_en   = arvalid && arready;
  assign regs.rd_addr = araddr;
  // write address and data hold until both are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full      <= 1'b0;
      w_full       <= 1'b0;
      awready      <= 1'b0;
      wready       <= 1'b0;
      bvalid       <= 1'b0;
      bresp        <= asc_pkg::RESP_OKAY;
      regs.wr_addr <= '0;
      regs.wr_data <= '0;
      regs.wr_strb <= '0;
    end else begin
      if (aw_take) begin
        aw_full      <= 1'b1;
        regs.wr_addr <= awaddr;
      end
      if (w_take) begin
        w_full       <= 1'b1;
        regs.wr_data <= wdata;
        regs.wr_strb <= wstrb;
      end
      awready <= aw_take ? 1'b0 : (awready || (!aw_full && !bvalid));
      wready  <= w_take ? 1'b0 : (wready || (!w_full && !bvalid));
      if (regs.wr_en) begin
        aw_full <= 1'b0;
        w_full  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= regs.wr_hit ? asc_pkg::RESP_OKAY : asc_pkg::RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end
  // read answer is registered one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= asc_pkg::RESP_OKAY;
    end else begin
      arready <= regs.rd_en ? 1'b0 : (arready || !rvalid);
      if (regs.rd_en) begin
        rvalid <= 1'b1;
        rdata  <= regs.rd_hit ? regs.rd_data : '0;
        rresp  <= regs.rd_hit ? asc_pkg::RESP_OKAY : asc_pkg::RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end
endmodule // asc_axil_slave

/* File: core/asc_input_decode.sv */
// decodes gain and input codes into one-hot routing selects
`timescale 1ns/1ps
module asc_input_decode (
  // configuration fields
  input  wire logic [1:0]                  gain_code,
  input  wire logic                        neg_select,
  input  wire logic [3:0]                  pos_code,
  // decoded routing
  output logic [2:0]                       gain_factor,
  output logic [asc_pkg::N_EXT-1:0]        ext_sel,
  output logic [asc_pkg::N_INT-1:0]        int_sel,
  output logic                             neg_ext7,
  output logic                             neg_auto
);
  // codes with the top bit set are internal and pick the negative side
  wire internal = pos_code[3];
  assign neg_auto = internal;
  assign neg_ext7 = neg_select && !internal;
  // both upper gain codes mean a factor of four
  assign gain_factor = (gain_code == asc_pkg::GAIN_C1) ? asc_pkg::GAIN_X1 :
                       (gain_code == asc_pkg::GAIN_C2) ? asc_pkg::GAIN_X2 :
                       asc_pkg::GAIN_X4;
  // one select line per external and per internal source
  for (genvar i = 0; i < asc_pkg::N_EXT; i++) begin : g_sel
    assign ext_sel[i] = !internal && (pos_code[2:0] == 3'(i));
    assign int_sel[i] = internal && (pos_code[2:0] == 3'(i));
  end
endmodule // asc_input_decode

/* File: core/asc_step8_cfg.sv */
// step 8 configuration register of converter a with axi4-lite access
//
// What this block does
// - bit 15 set includes step 8
// - gain bits 14:13 give 1, 2, 4, 4
// - bit 4 picks ground or input 7
// - codes 0-7 external, 8 temperature sensor
// - code 9 ground short, 10 test dac
// - codes 11-15 select supply monitor points
// - internal codes override negative select bit
// - register at index 98h, resets 0008h
//
// Decided for this implementation: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/1ps
module asc_step8_cfg (
  // clock and reset
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // axi4-lite write channels
  input  wire logic [asc_pkg::ADDR_W-1:0]    awaddr,
  input  wire logic                          awvalid,
  output logic                               awready,
  input  wire logic [asc_pkg::DATA_W-1:0]    wdata,
  input  wire logic [asc_pkg::DATA_W/8-1:0]  wstrb,
  input  wire logic                          wvalid,
  output logic                               wready,
  output logic [1:0]                         bresp,
  output logic                               bvalid,
  input  wire logic                          bready,
  // axi4-lite read channels
  input  wire logic [asc_pkg::ADDR_W-1:0]    araddr,
  input  wire logic                          arvalid,
  output logic                               arready,
  output logic [asc_pkg::DATA_W-1:0]         rdata,
  output logic [1:0]                         rresp,
  output logic                               rvalid,
  input  wire logic                          rready,
  // step 8 controls toward the sequencer and input mux
  output logic                               step8_enable,
  output logic [2:0]                         gain_factor,
  output logic [asc_pkg::N_EXT-1:0]          pos_external,
  output logic [asc_pkg::N_INT-1:0]          pos_internal,
  output logic                               neg_external_7,
  output logic                               neg_automatic
);
  // ----------------------------------------------------------------
  // bus front end
  // ----------------------------------------------------------------
  asc_reg_if regs ();

  asc_axil_slave u_slave (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .regs    (regs)
  );

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  logic [asc_pkg::CFG_W-1:0] cfg;
  logic [asc_pkg::CFG_W-1:0] next_cfg;
  logic [asc_pkg::CFG_W-1:0] lane_mask;
  logic [asc_pkg::CFG_W-1:0] wr_value;
  logic                      wr_take;

  // only the word at the step 8 index answers; low bits are byte lanes
  assign regs.wr_hit = regs.wr_addr[asc_pkg::ADDR_W-1:2]
                       == asc_pkg::STEP8_ADDR[asc_pkg::ADDR_W-1:2];
  assign regs.rd_hit = regs.rd_addr[asc_pkg::ADDR_W-1:2]
                       == asc_pkg::STEP8_ADDR[asc_pkg::ADDR_W-1:2];
  // upper sixteen data bits read as zero
  assign regs.rd_data = {{(asc_pkg::DATA_W-asc_pkg::CFG_W){1'b0}}, cfg};

  // ----------------------------------------------------------------
  // write merge
  // ----------------------------------------------------------------
  // byte lanes 0 and 1 carry the register; reserved bits never stored
  assign wr_take   = regs.wr_en && regs.wr_hit;
  assign lane_mask = {{8{regs.wr_strb[1]}}, {8{regs.wr_strb[0]}}};
  assign wr_value  = (cfg & ~lane_mask)
                     | (regs.wr_data[asc_pkg::CFG_W-1:0] & lane_mask
                        & asc_pkg::CFG_WMASK);
  assign next_cfg  = wr_take ? wr_value : cfg;

  // ----------------------------------------------------------------
  // routing decode of the value about to be stored
  // ----------------------------------------------------------------
  logic [2:0]                next_gain;
  logic [asc_pkg::N_EXT-1:0] next_ext;
  logic [asc_pkg::N_INT-1:0] next_int;
  logic                      next_neg_ext7;
  logic                      next_neg_auto;

  // decoding next_cfg lets outputs move on the same edge as cfg
  asc_input_decode u_decode (
    .gain_code   (next_cfg[asc_pkg::GAIN_HI:asc_pkg::GAIN_LO]),
    .neg_select  (next_cfg[asc_pkg::NEG_BIT]),
    .pos_code    (next_cfg[asc_pkg::POS_HI:asc_pkg::POS_LO]),
    .gain_factor (next_gain),
    .ext_sel     (next_ext),
    .int_sel     (next_int),
    .neg_ext7    (next_neg_ext7),
    .neg_auto    (next_neg_auto)
  );

  // ----------------------------------------------------------------
  // register and registered controls
  // ----------------------------------------------------------------
  // stored word, reset to step off, gain 1, temperature sensor
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg <= asc_pkg::CFG_RESET;
    end else begin
      cfg <= next_cfg;
    end
  end

  // step enable and decoded gain registered from the value about to be stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      step8_enable <= 1'b0;
      gain_factor  <= asc_pkg::GAIN_X1;
    end else begin
      step8_enable <= next_cfg[asc_pkg::EN_BIT];
      gain_factor  <= next_gain;
    end
  end

  // positive and negative input routing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pos_external   <= '0;
      pos_internal   <= asc_pkg::RST_INT_SEL;
      neg_external_7 <= 1'b0;
      neg_automatic  <= 1'b1;
    end else begin
      pos_external   <= next_ext;
      pos_internal   <= next_int;
      neg_external_7 <= next_neg_ext7;
      neg_automatic  <= next_neg_auto;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  wire [3:0] pos_now = cfg[asc_pkg::POS_HI:asc_pkg::POS_LO];
  wire [1:0] gain_now = cfg[asc_pkg::GAIN_HI:asc_pkg::GAIN_LO];

  // a write to the step 8 word, and its response
  sequence s_hit_write;
    regs.wr_en && regs.wr_hit;
  endsequence
  sequence s_ok_answer;
    bvalid && (bresp == asc_pkg::RESP_OKAY);
  endsequence

  property p_enable;
    step8_enable == cfg[asc_pkg::EN_BIT];
  endproperty
  a_enable: assert property (p_enable)
    else $error("step enable does not follow bit 15");

  property p_gain;
    (gain_now == 2'h0 && gain_factor == 3'h1)
    || (gain_now == 2'h1 && gain_factor == 3'h2)
    || (gain_now[1] && gain_factor == 3'h4);
  endproperty
  a_gain: assert property (p_gain)
    else $error("gain factor does not match gain code");

  property p_neg_route;
    !pos_now[3] |-> neg_external_7 == cfg[asc_pkg::NEG_BIT];
  endproperty
  a_neg_route: assert property (p_neg_route)
    else $error("negative input does not follow bit 4");

  property p_ext_decode;
    !pos_now[3] |-> (pos_external == (8'h01 << pos_now[2:0]))
                    && (pos_internal == 8'h00);
  endproperty
  a_ext_decode: assert property (p_ext_decode)
    else $error("external input select wrong");

  property p_temp;
    (pos_now == 4'h8) |-> pos_internal == 8'h01 && pos_external == 8'h00;
  endproperty
  a_temp: assert property (p_temp)
    else $error("temperature sensor not selected for code 8");

  property p_short_tdac;
    ((pos_now == 4'h9) |-> pos_internal == 8'h02)
    and ((pos_now == 4'hA) |-> pos_internal == 8'h04);
  endproperty
  a_short_tdac: assert property (p_short_tdac)
    else $error("short or test dac select wrong");

  property p_monitor;
    ((pos_now == 4'hB) |-> pos_internal == 8'h08)
    and ((pos_now == 4'hD) |-> pos_internal == 8'h20)
    and ((pos_now == 4'hE) |-> pos_internal == 8'h40)
    and ((pos_now == 4'hF) |-> pos_internal == 8'h80);
  endproperty
  a_monitor: assert property (p_monitor)
    else $error("monitor point select wrong");

  property p_neg_ignore;
    pos_now[3] |-> neg_automatic && !neg_external_7;
  endproperty
  a_neg_ignore: assert property (p_neg_ignore)
    else $error("negative select not overridden");

  property p_reset_value;
    disable iff (1'b0)
    !aresetn ##1 aresetn |-> cfg == 16'h0008 && !step8_enable;
  endproperty
  a_reset_value: assert property (p_reset_value)
    else $error("register not at reset value after reset");

  property p_write_lands;
    s_hit_write ##0 (regs.wr_strb[1:0] == 2'h3)
    |=> cfg == ($past(regs.wr_data[15:0]) & 16'hE01F) ##0 s_ok_answer;
  endproperty
  a_write_lands: assert property (p_write_lands)
    else $error("write to step 8 word did not land");

  property p_miss_keeps;
    regs.wr_en && !regs.wr_hit |=> $stable(cfg)
      && bvalid && bresp == asc_pkg::RESP_SLVERR;
  endproperty
  a_miss_keeps: assert property (p_miss_keeps)
    else $error("unmapped write changed register or answered okay");

  property p_reserved;
    (cfg[asc_pkg::RSV_HI:asc_pkg::RSV_LO] == 8'h00)
    and (rvalid |-> rdata[12:5] == 8'h00);
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bits not zero");

  // io supply monitor code also takes its negative input automatically
  property p_io_monitor;
    (pos_now == 4'hC) |-> pos_internal == 8'h10 && neg_automatic;
  endproperty
  a_io_monitor: assert property (p_io_monitor)
    else $error("io supply monitor select wrong");

  // exactly one positive source is routed at any time
  property p_one_source;
    $onehot({pos_external, pos_internal});
  endproperty
  a_one_source: assert property (p_one_source)
    else $error("positive input select not one-hot");

  // the stored word only moves on a write strobe
  property p_cfg_quiet;
    !regs.wr_en |=> $stable(cfg);
  endproperty
  a_cfg_quiet: assert property (p_cfg_quiet)
    else $error("register changed without a write");

  // the internal write strobe lasts one cycle, so a write lands once
  property p_one_strobe;
    regs.wr_en |=> !regs.wr_en;
  endproperty
  a_one_strobe: assert property (p_one_strobe)
    else $error("write strobe held for more than one cycle");

  // a low byte write leaves the high byte alone
  property p_low_lane;
    s_hit_write ##0 (regs.wr_strb[1:0] == 2'h1)
    |=> cfg[15:8] == $past(cfg[15:8]) ##0 s_ok_answer;
  endproperty
  a_low_lane: assert property (p_low_lane)
    else $error("low byte write disturbed the high byte");

  // a read of the word is answered on the next cycle with the stored value
  property p_read_answer;
    regs.rd_en && regs.rd_hit
    |=> rvalid && rresp == asc_pkg::RESP_OKAY
        && rdata == {16'h0000, $past(cfg)};
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read answer late or wrong");

  // an unmapped read answers zero with an error response
  property p_miss_read;
    regs.rd_en && !regs.rd_hit
    |=> rvalid && rresp == asc_pkg::RESP_SLVERR
        && rdata == 32'h0000_0000;
  endproperty
  a_miss_read: assert property (p_miss_read)
    else $error("unmapped read not refused");

endmodule // asc_step8_cfg

/* File: tb/test_asc_step8_cfg.sv */
// self-checking bench for the step 8 configuration register over axi4-lite
`timescale 1ns/1ps
module test_asc_step8_cfg;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        aclk;
  logic        aresetn;
  logic [11:0] awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [11:0] araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        step8_enable;
  logic [2:0]  gain_factor;
  logic [7:0]  pos_external;
  logic [7:0]  pos_internal;
  logic        neg_external_7;
  logic        neg_automatic;
  logic [15:0] model;
  int          fails;
  int          n_compared;
  // ----------------------------------------------------------------
  // device under test
  // ----------------------------------------------------------------
  asc_step8_cfg uut (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .step8_enable(step8_enable), .gain_factor(gain_factor),
    .pos_external(pos_external), .pos_internal(pos_internal),
    .neg_external_7(neg_external_7), .neg_automatic(neg_automatic)
  );
  // ----------------------------------------------------------------
  // common tasks
  // ----------------------------------------------------------------
  // verdict and end of run
  task automatic complete_run();
    if (fails == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // one comparison
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // a wait that used up its bound ends the run
  task automatic bound_hit(input int n);
    if (n >= 100) begin
      fails++;
      $display("Error handshake wait expected answer seen none");
      complete_run();
    end
  endtask
  // one write, both channels offered together, response checked
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                           input logic [1:0] er);
    int   n;
    logic aw_done;
    logic w_done;
    aw_done = 0;
    w_done = 0;
    n = 0;
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= s;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!(aw_done && w_done) && n < 100) begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) begin
        aw_done = 1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        w_done = 1;
        wvalid <= 1'b0;
      end
    end
    bound_hit(n);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (bvalid !== 1'b1 && n < 100);
    bound_hit(n);
    check("bresp", {30'h0, bresp}, {30'h0, er});
    bready <= 1'b0;
    if (er === asc_pkg::RESP_OKAY) begin
      if (s[0]) model[7:0] = d[7:0];
      if (s[1]) model[15:8] = d[15:8];
      model = model & asc_pkg::CFG_WMASK;
    end
  endtask
  // one read, data and response checked
  task automatic axi_read(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (arready !== 1'b1 && n < 100);
    bound_hit(n);
    arvalid <= 1'b0;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (rvalid !== 1'b1 && n < 100);
    bound_hit(n);
    check("rdata", rdata, ed);
    check("rresp", {30'h0, rresp}, {30'h0, er});
    rready <= 1'b0;
  endtask
  // step outputs against the expected stored word, sampled off the edge
  task automatic check_outputs();
    logic [3:0] c;
    logic [2:0] g;
    c = model[3:0];
    g = (model[14:13] == 2'h0) ? 3'h1 : (model[14:13] == 2'h1) ? 3'h2 : 3'h4;
    @(negedge aclk);
    check("step8_enable", {31'h0, step8_enable}, {31'h0, model[15]});
    check("gain_factor", {29'h0, gain_factor}, {29'h0, g});
    check("pos_external", {24'h0, pos_external}, c[3] ? 32'h0 : 32'h1 << c[2:0]);
    check("pos_internal", {24'h0, pos_internal}, c[3] ? 32'h1 << c[2:0] : 32'h0);
    check("neg_external_7", {31'h0, neg_external_7}, {31'h0, model[4] & ~c[3]});
    check("neg_automatic", {31'h0, neg_automatic}, {31'h0, c[3]});
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // reset value, read back and decoded
  task automatic test_reset();
    check("reset pos_internal", {24'h0, pos_internal}, 32'h0000_0001);
    axi_read(asc_pkg::STEP8_ADDR, 32'h0000_0008, asc_pkg::RESP_OKAY);
    check_outputs();
  endtask
  // every positive code with the negative select set
  task automatic test_pos_codes();
    for (int c = 0; c < 16; c++) begin
      axi_write(asc_pkg::STEP8_ADDR, 32'h0000_0010 | c, 4'h3, asc_pkg::RESP_OKAY);
      check_outputs();
      axi_read(asc_pkg::STEP8_ADDR, {16'h0, model}, asc_pkg::RESP_OKAY);
    end
  endtask
  // every gain code, enable toggled, negative select clear
  task automatic test_gain_enable();
    for (int g = 0; g < 4; g++) begin
      axi_write(asc_pkg::STEP8_ADDR, {16'h0, g[0], g[1:0], 13'h0007}, 4'h3, asc_pkg::RESP_OKAY);
      check_outputs();
    end
  endtask
  // reserved bits and byte strobes
  task automatic test_reserved_strobes();
    axi_write(asc_pkg::STEP8_ADDR, 32'hFFFF_FFFF, 4'hF, asc_pkg::RESP_OKAY);
    axi_read(asc_pkg::STEP8_ADDR, 32'h0000_E01F, asc_pkg::RESP_OKAY);
    axi_write(asc_pkg::STEP8_ADDR, 32'h0000_0002, 4'h1, asc_pkg::RESP_OKAY);
    axi_read(asc_pkg::STEP8_ADDR, 32'h0000_E002, asc_pkg::RESP_OKAY);
    check_outputs();
    axi_write(asc_pkg::STEP8_ADDR, 32'h0000_1FE0, 4'h2, asc_pkg::RESP_OKAY);
    axi_read(asc_pkg::STEP8_ADDR, {16'h0, model}, asc_pkg::RESP_OKAY);
  endtask
  // neighbouring addresses are refused and leave the word alone
  task automatic test_unmapped();
    axi_write(12'h264, 32'h0000_0000, 4'h3, asc_pkg::RESP_SLVERR);
    axi_write(12'h25C, 32'h0000_0000, 4'h3, asc_pkg::RESP_SLVERR);
    axi_read(12'h25C, 32'h0000_0000, asc_pkg::RESP_SLVERR);
    axi_read(asc_pkg::STEP8_ADDR, {16'h0, model}, asc_pkg::RESP_OKAY);
    check_outputs();
  endtask
  // ----------------------------------------------------------------
  // clock, reset and main sequence
  // ----------------------------------------------------------------
  // 250 mhz clock
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // stimulus
  initial begin
    fails = 0;
    n_compared = 0;
    model = 16'h0008;
    aresetn = 1'b0;
    awaddr = 12'h000;
    awvalid = 1'b0;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 12'h000;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    test_reset();
    test_pos_codes();
    test_gain_enable();
    test_reserved_strobes();
    test_unmapped();
    complete_run();
  end
endmodule // test_asc_step8_cfg
